//--- home_return_sequencer.sv
// Home position return sequencer for one servo axis.
// Assumes the controller word, method, encoder position and stall flag come
// from logic on mclk; the dog switch and index pulse are raw pins.
`default_nettype none
module home_return_sequencer
  import home_pkg::*;
(
  input wire logic mclk,                       // 40 MHz system clock.
  input wire logic nrst,                       // Asynchronous reset, active low.
  input wire logic [CW_W-1:0] ctrl_word,       // Control word from controller.
  input wire logic signed [7:0] method_code,   // Homing method number.
  input wire logic abs_mode,                   // 1: absolute position detection.
  input wire logic abs_home_kept,              // Homed state held by backed-up encoder.
  input wire logic dog_pin,                    // Proximity dog switch pin.
  input wire logic index_pin,                  // Encoder Z-phase pin.
  input wire logic stalled,                    // Torque limit reached, axis halted.
  input wire logic signed [POS_W-1:0] enc_pos, // Current machine position.
  input wire logic [POS_W-1:0] post_dog_dist,  // Travel distance after dog.
  input wire logic [POS_W-1:0] shift_dist,     // Home position shift distance.
  output motion_cmd_t motion,                  // Motion command to the drive.
  output home_status_t status,                 // Homing status.
  output logic signed [POS_W-1:0] home_pos     // Machine position taken as home.
);
  typedef enum logic [3:0] {
    s_idle, s_seek, s_rear, s_back, s_dist, s_zseek, s_press, s_done
  } state_t;

  state_t state_reg;
  method_kind_t kind_reg;
  method_kind_t kind_next;
  logic rev_next;
  logic start_prev_reg;
  logic start_rise;
  logic start_lvl;
  logic after_z_reg;
  logic strap_done_reg;
  logic [POS_W-1:0] dist_reg;
  logic signed [POS_W-1:0] ref_reg;
  logic signed [POS_W-1:0] moved;
  logic [POS_W-1:0] moved_abs;
  logic [DWELL_W-1:0] dwell_reg;
  logic dog_lvl;
  logic dog_rise;
  logic dog_fall;
  logic z_rise;
  logic dist_reached;
  logic set_home;

  // Both pins pass the three-stage filter, so their edge pulses trail the
  // pin by about four cycles; positions are latched when the pulse arrives.
  edge_sync dog_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(dog_pin),
    .level(dog_lvl),
    .rise(dog_rise),
    .fall(dog_fall)
  );

  edge_sync idx_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin(index_pin),
    .level(),
    .rise(z_rise),
    .fall()
  );

  // Method number decode: magnitude 1..11 is forward, 33..42 is reverse.
  always_comb
  begin
    logic [7:0] mag;
    logic [7:0] base;
    mag = 8'(-method_code);
    base = mag;
    rev_next = mag > REV_OFFSET;
    if (rev_next)
      base = 8'(mag - REV_OFFSET);
    case (base)
      M_DOG_REAR_Z: kind_next = k_dog_rear_z;
      M_COUNT_Z: kind_next = k_count_z;
      M_STOPPER: kind_next = k_stopper;
      M_DOG_REAR_REF: kind_next = k_dog_rear_ref;
      M_COUNT_FRONT: kind_next = k_count_front;
      M_CRADLE: kind_next = k_cradle;
      M_LAST_Z: kind_next = k_last_z;
      M_DOG_FRONT_REF: kind_next = k_dog_front_ref;
      M_DOGLESS_Z: kind_next = rev_next ? k_bad : k_dogless_z;
      default: kind_next = k_bad;
    endcase
    if (method_code >= 8'sh00)
      kind_next = k_bad;
  end

  assign start_lvl = ctrl_word[CW_HOME_BIT];
  assign start_rise = start_lvl && !start_prev_reg;
  // Travel is measured as a magnitude from the latched reference, so one
  // compare serves both directions.
  assign moved = enc_pos - ref_reg;
  assign moved_abs = moved[POS_W-1] ? POS_W'(-moved) : POS_W'(moved);
  assign dist_reached = moved_abs >= dist_reg;
  assign set_home = (state_reg == s_done);

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      start_prev_reg <= 1'b0;
    else
      start_prev_reg <= start_lvl;
  end

  // Sequencer. Dropping the start bit before s_done aborts and leaves home incomplete.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= s_idle;
      kind_reg <= k_bad;
      after_z_reg <= 1'b0;
      dist_reg <= '0;
      ref_reg <= '0;
      dwell_reg <= '0;
    end
    else if (state_reg != s_idle && !start_lvl)
      state_reg <= s_idle;
    else
    begin
      case (state_reg)
        s_idle:
        begin
          after_z_reg <= 1'b0;
          dwell_reg <= '0;
          if (start_rise)
          begin
            kind_reg <= kind_next;
            if (kind_next == k_stopper)
              state_reg <= s_press;
            else if (kind_next == k_dogless_z)
              state_reg <= s_zseek;
            else if (kind_next != k_bad)
              state_reg <= s_seek;
          end
        end
        s_seek:
          if (dog_rise)
          begin
            ref_reg <= enc_pos;
            case (kind_reg)
              k_dog_rear_z, k_dog_rear_ref: state_reg <= s_rear;
              k_last_z: state_reg <= s_back;
              k_cradle: state_reg <= s_zseek;
              k_count_z:
              begin
                dist_reg <= post_dog_dist;
                state_reg <= s_dist;
              end
              default:
              begin
                dist_reg <= POS_W'(post_dog_dist + shift_dist);
                state_reg <= s_dist;
              end
            endcase
          end
        s_rear:
          if (dog_fall)
          begin
            ref_reg <= enc_pos;
            if (kind_reg == k_dog_rear_ref)
            begin
              dist_reg <= POS_W'(post_dog_dist + shift_dist);
              state_reg <= s_dist;
            end
            else
              state_reg <= s_zseek;
          end
        s_back:
          // Wait until the dog is fully left, so an index mark under the dog
          // is never taken as home.
          if (!dog_lvl)
            state_reg <= s_zseek;
        s_dist:
          if (dist_reached)
          begin
            if (kind_reg == k_count_z && !after_z_reg)
              state_reg <= s_zseek;
            else
              state_reg <= s_done;
          end
        s_zseek:
          if (z_rise)
          begin
            after_z_reg <= 1'b1;
            ref_reg <= enc_pos;
            if (kind_reg == k_cradle)
              state_reg <= s_done;
            else
            begin
              dist_reg <= shift_dist;
              state_reg <= s_dist;
            end
          end
        s_press:
          // Any release of the stall restarts the dwell, so a brief torque
          // peak while accelerating is not mistaken for the stopper.
          if (!stalled)
            dwell_reg <= '0;
          else if (dwell_reg == DWELL_W'(STOP_DWELL_CYC - 1))
            state_reg <= s_done;
          else
            dwell_reg <= DWELL_W'(dwell_reg + 1'b1);
        s_done:
          state_reg <= s_idle;
        default:
          state_reg <= s_idle;
      endcase
    end
  end

  // Motion command follows the state; direction and speed per phase.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      motion <= '0;
    else
    begin
      case (state_reg)
        s_idle:
        begin
          motion.run <= 1'b0;
          motion.creep <= 1'b0;
          if (start_rise)
            motion.positive <= !rev_next;
        end
        s_seek:
        begin
          motion.run <= 1'b1;
          motion.creep <= dog_rise && kind_reg != k_dog_front_ref;
          if (dog_rise && kind_reg == k_last_z)
            motion.positive <= !motion.positive;
        end
        s_rear, s_back, s_dist, s_zseek, s_press:
        begin
          motion.run <= !(state_reg == s_dist && dist_reached) &&
                        !(state_reg == s_zseek && z_rise && kind_reg == k_cradle);
          motion.creep <= 1'b1;
        end
        default:
        begin
          motion.run <= 1'b0;
          motion.creep <= 1'b0;
        end
      endcase
      if (state_reg != s_idle && !start_lvl)
        motion.run <= 1'b0;
    end
  end

  // Strap capture one cycle after reset release; reset itself loses home.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      strap_done_reg <= 1'b0;
    else
      strap_done_reg <= 1'b1;
  end

  // A start needs s_idle and set_home needs s_done, so the two never meet.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      status <= '0;
      home_pos <= HOME_POS_RST;
    end
    else
    begin
      status.busy <= state_reg != s_idle && state_reg != s_done && start_lvl;
      status.home_pulse <= set_home;
      if (!strap_done_reg)
        status.home_valid <= abs_mode && abs_home_kept;
      else if (set_home)
        status.home_valid <= 1'b1;
      else if (state_reg == s_idle && start_rise)
        status.home_valid <= 1'b0;
      if (set_home)
        home_pos <= enc_pos;
      if (state_reg == s_idle && start_rise)
        status.bad_method <= kind_next == k_bad;
    end
  end
endmodule : home_return_sequencer
`default_nettype wire

//--- home_pkg.sv
// Shared types and constants for the home position return sequencer.
// Assumes a single 40 MHz clock domain.
`default_nettype none
package home_pkg;
  localparam int POS_W = 32;
  localparam int CW_W = 16;
  // Control word bit that requests a home position return.
  localparam int CW_HOME_BIT = 4;
  localparam int CLK_PERIOD_NS = 25;
  // Stall must persist this long before the stopper position is accepted.
  localparam int STOP_DWELL_NS = 2000;
  localparam int STOP_DWELL_CYC =
    ((STOP_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    ((STOP_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int DWELL_W = $clog2(STOP_DWELL_CYC + 1);
  // Method numbers are negative; the reverse twin is the forward one minus 32.
  localparam logic [7:0] REV_OFFSET = 8'h20;
  localparam logic [7:0] M_DOG_REAR_Z = 8'h01;
  localparam logic [7:0] M_COUNT_Z = 8'h02;
  localparam logic [7:0] M_STOPPER = 8'h04;
  localparam logic [7:0] M_DOG_REAR_REF = 8'h06;
  localparam logic [7:0] M_COUNT_FRONT = 8'h07;
  localparam logic [7:0] M_CRADLE = 8'h08;
  localparam logic [7:0] M_LAST_Z = 8'h09;
  localparam logic [7:0] M_DOG_FRONT_REF = 8'h0A;
  localparam logic [7:0] M_DOGLESS_Z = 8'h0B;
  localparam logic [POS_W-1:0] HOME_POS_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    k_dog_rear_z, k_count_z, k_stopper, k_dog_rear_ref, k_count_front,
    k_cradle, k_last_z, k_dog_front_ref, k_dogless_z, k_bad
  } method_kind_t;

  typedef struct packed {
    logic run;      // Axis is commanded to move.
    logic positive; // 1: forward (CCW), 0: reverse (CW).
    logic creep;    // 1: creep speed, 0: homing speed.
  } motion_cmd_t;

  typedef struct packed {
    logic busy;        // Homing sequence in progress.
    logic home_valid;  // Home position established.
    logic home_pulse;  // One cycle when home is set.
    logic bad_method;  // Last start carried an unsupported method.
  } home_status_t;
endpackage : home_pkg
`default_nettype wire

//--- edge_sync.sv
// Three-stage synchroniser for a pin input, with rise and fall pulses.
// Assumes the pin is asynchronous to mclk.
`default_nettype none
module edge_sync
  import home_pkg::*;
(
  input wire logic mclk,     // System clock.
  input wire logic nrst,     // Asynchronous reset, active low.
  input wire logic pin,      // Raw pin level.
  output logic level,        // Filtered level.
  output logic rise,         // One-cycle pulse on 0 to 1.
  output logic fall          // One-cycle pulse on 1 to 0.
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      rise <= (s2_reg == s3_reg) && s3_reg && !level;
      fall <= (s2_reg == s3_reg) && !s3_reg && level;
      if (s2_reg == s3_reg)
        level <= s3_reg;
    end
  end
endmodule : edge_sync
`default_nettype wire

//--- home_return_sequencer_assertions.sv
// Port checks for the home return sequencer.
// Assumes one mclk domain and the home_pkg constants.
`default_nettype none
module hrs_checker
  import home_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic [CW_W-1:0] ctrl_word, // Control word.
  input wire logic signed [7:0] method_code, // Method number.
  input wire logic signed [POS_W-1:0] enc_pos, // Machine position.
  input wire motion_cmd_t motion, // Motion command.
  input wire home_status_t status, // Status.
  input wire logic signed [POS_W-1:0] home_pos // Home position.
);
  logic fwd_ok;
  logic rev_ok;
  assign fwd_ok = method_code inside {-1, -2, -4, [-11:-6]};
  assign rev_ok = method_code inside {-33, -34, -36, [-42:-38]};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_dir_fwd;
    $rose(ctrl_word[CW_HOME_BIT]) && !status.busy && fwd_ok |=> motion.positive;
  endproperty
  property p_dir_rev;
    $rose(ctrl_word[CW_HOME_BIT]) && !status.busy && rev_ok |=>
      !motion.positive ##1 (motion.run && !motion.positive);
  endproperty
  property p_run;
    $rose(ctrl_word[CW_HOME_BIT]) && !status.busy && (fwd_ok || rev_ok) |-> ##2 motion.run;
  endproperty
  property p_bad;
    $rose(ctrl_word[CW_HOME_BIT]) && !status.busy && !(fwd_ok || rev_ok) |=>
      (status.bad_method && !motion.run) [*3];
  endproperty
  property p_bad_hold;
    status.bad_method |-> !status.home_valid && !motion.run;
  endproperty
  property p_clear;
    $rose(ctrl_word[CW_HOME_BIT]) && !status.busy |=> !status.home_valid;
  endproperty
  property p_pulse;
    status.home_pulse |-> (status.home_valid && !status.busy) ##1 !status.home_pulse;
  endproperty
  property p_cap;
    status.home_pulse |-> home_pos == $past(enc_pos);
  endproperty
  property p_abort;
    status.busy && !ctrl_word[CW_HOME_BIT] |=> !motion.run && !status.home_valid;
  endproperty
  a_dir_fwd: assert property (p_dir_fwd) else $error("forward code moved reverse");
  a_dir_rev: assert property (p_dir_rev) else $error("reverse code moved forward");
  a_run: assert property (p_run) else $error("no motion after start");
  a_bad: assert property (p_bad) else $error("bad code not refused");
  a_bad_hold: assert property (p_bad_hold) else $error("refused yet moving or valid");
  a_clear: assert property (p_clear) else $error("start kept home valid");
  a_pulse: assert property (p_pulse) else $error("home pulse malformed");
  a_cap: assert property (p_cap) else $error("home position not captured");
  a_abort: assert property (p_abort) else $error("abort did not stop axis");
  c_home: cover property (status.home_pulse);
  c_bad: cover property (status.bad_method);
  c_abort: cover property (status.busy && !ctrl_word[CW_HOME_BIT]);
endmodule : hrs_checker
bind home_return_sequencer hrs_checker hrs_checker_inst (.mclk(mclk), .nrst(nrst),
  .ctrl_word(ctrl_word), .method_code(method_code), .enc_pos(enc_pos),
  .motion(motion), .status(status), .home_pos(home_pos));
`default_nettype wire

//--- axis_model.sv
// Behavioural axis: position counter, dog cam, index marks and hard stops.
// Assumes the motion command comes from the sequencer on mclk.
`default_nettype none
module axis_model
  import home_pkg::*;
(
  input wire logic mclk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire motion_cmd_t motion, // Motion command.
  input wire logic load, // Place the axis at load_pos.
  input wire logic signed [POS_W-1:0] load_pos, // Preset position.
  output logic signed [POS_W-1:0] enc_pos, // Position.
  output logic dog_pin, // Dog cam over 100 to 139 from zero.
  output logic index_pin, // High while the low six bits are zero.
  output logic stalled // Pressing a stop at 200 from zero.
);
  logic [3:0] tick_reg;
  logic [POS_W-1:0] mag;
  logic wall;
  assign mag = enc_pos < 0 ? -enc_pos : enc_pos;
  assign dog_pin = mag >= 32'h64 && mag < 32'h8C;
  assign index_pin = enc_pos[5:0] == 6'h00;
  assign wall = mag == 32'hC8 && ((enc_pos < 0) != motion.positive);
  assign stalled = motion.run && wall;
  // One step per 16 cycles keeps every mark wider than the pin synchroniser needs.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      tick_reg <= 4'h0;
    else
      tick_reg <= tick_reg + 4'h1;
  end
  always_ff @(posedge mclk)
  begin
    if (load)
      enc_pos <= load_pos;
    else if (motion.run && tick_reg == 4'hF && !wall)
      enc_pos <= motion.positive ? enc_pos + 32'sh1 : enc_pos - 32'sh1;
  end
endmodule : axis_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench: the sequencer drives a behavioural axis.
// Assumes home_pkg, the sequencer, its checker and axis_model are compiled first.
`default_nettype none
module tb_top
  import home_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, nrst = 0, abs_mode = 0, abs_home_kept = 0, load = 0;
  logic [CW_W-1:0] ctrl_word = '0;
  logic signed [7:0] method_code = 8'h00;
  logic [POS_W-1:0] post_dog_dist = 32'h14, shift_dist = 32'h0;
  logic signed [POS_W-1:0] load_pos = 32'h0A, enc_pos, home_pos;
  logic dog_pin, index_pin, stalled;
  motion_cmd_t motion;
  home_status_t status;
  int n_fail = 0, total_checks = 0;
  always #12.5 mclk = ~mclk;
  home_return_sequencer home_return_sequencer_inst (.mclk(mclk), .nrst(nrst),
    .ctrl_word(ctrl_word), .method_code(method_code), .abs_mode(abs_mode),
    .abs_home_kept(abs_home_kept), .dog_pin(dog_pin), .index_pin(index_pin),
    .stalled(stalled), .enc_pos(enc_pos), .post_dog_dist(post_dog_dist),
    .shift_dist(shift_dist), .motion(motion), .status(status), .home_pos(home_pos));
  axis_model axis_model_inst (.mclk(mclk), .nrst(nrst), .motion(motion), .load(load),
    .load_pos(load_pos), .enc_pos(enc_pos), .dog_pin(dog_pin), .index_pin(index_pin),
    .stalled(stalled));
  task automatic chk(input logic [POS_W-1:0] got, input logic [POS_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic go(input logic signed [7:0] code);
    @(posedge mclk);
    method_code <= code;
    ctrl_word[CW_HOME_BIT] <= 1'b1;
  endtask : go
  task automatic halt;
    @(posedge mclk);
    ctrl_word <= '0;
  endtask : halt
  task automatic t_reset(input logic a, input logic k);
    @(posedge mclk);
    nrst <= 1'b0;
    abs_mode <= a;
    abs_home_kept <= k;
    tick(8);
    @(posedge mclk);
    nrst <= 1'b1;
    tick(3);
    chk(status.home_valid, a & k);
    $display("reset test done");
  endtask : t_reset
  task automatic t_home(input logic signed [7:0] code, input logic [POS_W-1:0] from, sh, exp);
    int n;
    @(posedge mclk);
    load <= 1'b1;
    load_pos <= from;
    shift_dist <= sh;
    @(posedge mclk);
    load <= 1'b0;
    go(code);
    n = 0;
    while (status.home_pulse !== 1'b1 && n < 8000)
    begin
      tick(1);
      n++;
    end
    chk(status.home_pulse, 1'b1);
    chk(home_pos, exp);
    chk(status.home_valid, 1'b1);
    halt;
    $display("homing test done");
  endtask : t_home
  task automatic t_codes(input logic signed [7:0] c, input logic bad);
    go(c);
    tick(3);
    chk(status.bad_method, bad);
    chk(motion.run, !bad);
    chk(status.busy, !bad);
    if (!bad && c != 8'shFC && c != 8'shDC && c != 8'shF5)
      chk(motion.creep, 1'b0);
    if (!bad)
      chk(motion.positive, c[5]);
    halt;
    tick(2);
    chk(motion.run, 1'b0);
    chk(status.home_valid, 1'b0);
  endtask : t_codes
  task automatic t_all_codes;
    logic signed [7:0] good [17] = '{8'hFF, 8'hFE, 8'hFC, 8'hFA, 8'hF9, 8'hF8, 8'hF7,
      8'hF6, 8'hF5, 8'hDF, 8'hDE, 8'hDC, 8'hDA, 8'hD9, 8'hD8, 8'hD7, 8'hD6};
    t_codes(8'hD5, 1'b1);
    t_codes(8'h00, 1'b1);
    t_codes(8'h05, 1'b1);
    foreach (good[i])
      t_codes(good[i], 1'b0);
    $display("code table test done");
  endtask : t_all_codes
  // About 25k cycles of traffic; the limit leaves ample margin.
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    summarize;
  end
  initial
  begin
    t_reset(1'b1, 1'b1);
    t_reset(1'b0, 1'b1);
    t_home(8'hF5, 32'h0A, 32'h05, 32'h45);
    t_all_codes;
    t_home(8'hFC, 32'h0A, 32'h00, 32'hC8);
    t_home(8'hF6, 32'h0A, 32'h08, 32'h80);
    t_home(8'hDC, 32'hFFFF_FFF6, 32'h00, 32'hFFFF_FF38);
    t_home(8'hFF, 32'h0A, 32'h04, 32'hC4);
    t_home(8'hFE, 32'h0A, 32'h02, 32'h82);
    t_home(8'hFA, 32'h0A, 32'h03, 32'hA3);
    t_home(8'hF9, 32'h0A, 32'h01, 32'h79);
    t_home(8'hF8, 32'h0A, 32'h05, 32'h80);
    t_home(8'hF7, 32'h0A, 32'h02, 32'h3E);
    t_home(8'hDF, 32'hFFFF_FFF6, 32'h04, 32'hFFFF_FF3C);
    t_reset(1'b0, 1'b1);
    summarize;
  end
endmodule : tb_top
`default_nettype wire
